// ===== pdc_top.sv
`timescale 1ns/100ps
module pdc_top import pdc_pkg::*; #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port (APB)
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Data mover master
    output logic m_req_out,
    output logic m_write_out,
    output logic [31:0] m_addr_out,
    output logic [1:0] m_size_out,
    output logic [31:0] m_wdata_out,
    input wire logic [31:0] m_rdata_in,
    input wire logic m_ready_in,
    // Peripheral handshake
    input wire logic [NCH-1:0] per_req_in,
    output logic [NCH-1:0] per_ack_out,
    // Interrupt
    output logic irq_out
);
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_READ = 2'h1, ST_WRITE = 2'h2} pdc_state_t;

    typedef struct packed {
        logic [NCH-1:0][CTL_W-1:0] ctl;
        logic [NCH-1:0][31:0] src;
        logic [NCH-1:0][31:0] dst;
        logic [NCH-1:0][CNT_W-1:0] cnt;
        logic [CC_W-1:0] crc_ctl;
        logic [31:0] crc_seed;
        logic [31:0] crc_src;
        logic [CNT_W-1:0] crc_cnt;
        logic [NREQ-1:0] sts;
        logic [NREQ-1:0] mask;
        pdc_state_t state;
        logic [3:0] cur;
        logic [31:0] hold;
        logic m_req;
        logic m_write;
        logic [31:0] m_addr;
        logic [1:0] m_size;
        logic [31:0] m_wdata;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic [NCH-1:0] ack;
        logic crc_go;
        logic [31:0] crc_data;
        logic [2:0] crc_len;
        logic seed_ld;
    } pdc_top_st_t;

    pdc_top_st_t s, nxt_s;
    logic [NREQ-1:0] req;
    logic [3:0] gnt;
    logic gnt_vld;
    logic crc_busy;
    logic [31:0] crc_raw;

    // Channel select from an address: {hit, index}
    function automatic logic [4:0] dec_ch(input logic [11:0] a);
        return {a < CH_LIMIT, 4'(a >> 4)};
    endfunction

    function automatic logic [31:0] crc_view(input logic [31:0] raw, input logic [CC_W-1:0] cc);
        logic [31:0] v;
        logic [31:0] m;
        m = pdc_poly_mask(cc[CC_POLY +: 2]);
        v = raw;
        if (cc[CC_OUT_REV]) begin
            v = {<<{raw}};
            v = v >> (32 - $countones(m));
        end
        if (cc[CC_OUT_CPL]) begin
            v = ~v;
        end
        return v & m;
    endfunction

    // Ready-to-serve vector; peripheral channels need their request
    for (genvar i = 0; i < NCH; i++) begin : g_req
        assign req[i] = s.ctl[i][CTL_EN] && s.cnt[i] != '0 &&
                        (s.ctl[i][CTL_DIR +: 2] == DIR_M2M || per_req_in[i]);
    end
    assign req[CRC_CH] = s.crc_ctl[CC_DMA] && s.crc_ctl[CC_DMA_GO] && s.crc_cnt != '0 &&
                         !crc_busy && !s.crc_go;

    pdc_arb #(.N(NREQ)) pdc_arb_i (
        .req_in(req),
        .gnt_out(gnt),
        .vld_out(gnt_vld)
    );

    pdc_crc pdc_crc_i (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .poly_in(s.crc_ctl[CC_POLY +: 2]),
        .in_rev_in(s.crc_ctl[CC_IN_REV]),
        .in_cpl_in(s.crc_ctl[CC_IN_CPL]),
        .seed_ld_in(s.seed_ld),
        .seed_in(s.crc_seed),
        .go_in(s.crc_go),
        .data_in(s.crc_data),
        .nbytes_in(s.crc_len),
        .busy_out(crc_busy),
        .crc_out(crc_raw)
    );

    logic acc;
    logic [4:0] hit;
    logic [3:0] ch;
    logic [3:0] fld;
    logic mapped;
    logic pio_wr;
    logic [31:0] rdv;
    logic [2:0] bytes;
    logic [CNT_W-1:0] take;

    always_comb begin
        nxt_s = s;
        nxt_s.ack = '0;
        nxt_s.crc_go = 1'b0;
        nxt_s.seed_ld = 1'b0;
        acc = psel_in && penable_in;
        hit = dec_ch(paddr_in);
        ch = hit[3:0];
        fld = paddr_in[3:0];
        mapped = hit[4] ? (paddr_in[1:0] == 2'h0) :
                 (paddr_in >= REG_STS && paddr_in <= REG_CRC_CNT && paddr_in[1:0] == 2'h0);
        pio_wr = pwrite_in && paddr_in == REG_CRC_WDATA;
        rdv = 32'h0;
        bytes = 3'h0;
        take = '0;
        if (hit[4]) begin
            unique case (fld)
                CH_CTL: rdv = {{(32 - CTL_W){1'b0}}, s.ctl[ch]};
                CH_SRC: rdv = s.src[ch];
                CH_DST: rdv = s.dst[ch];
                CH_CNT: rdv = {{(32 - CNT_W){1'b0}}, s.cnt[ch]};
                default: rdv = 32'h0;
            endcase
        end else begin
            unique case (paddr_in)
                REG_STS: rdv = {{(32 - NREQ){1'b0}}, s.sts};
                REG_MASK: rdv = {{(32 - NREQ){1'b0}}, s.mask};
                REG_CRC_CTL: rdv = {{(32 - CC_W){1'b0}}, s.crc_ctl};
                REG_CRC_SEED: rdv = s.crc_seed;
                REG_CRC_SUM: rdv = crc_view(crc_raw, s.crc_ctl);
                REG_CRC_SRC: rdv = s.crc_src;
                REG_CRC_CNT: rdv = {{(32 - CNT_W){1'b0}}, s.crc_cnt};
                default: rdv = 32'h0;
            endcase
        end

        // Register slave: one wait cycle; PIO data also waits for the CRC
        if (acc && !s.pready) begin
            if (!(pio_wr && !s.crc_ctl[CC_DMA] && (crc_busy || s.crc_go))) begin
                nxt_s.pready = 1'b1;
                nxt_s.prdata = rdv;
                nxt_s.pslverr = !mapped;
            end
        end else if (s.pready) begin
            nxt_s.pready = 1'b0;
            nxt_s.pslverr = 1'b0;
            if (acc && pwrite_in && mapped) begin
                if (hit[4]) begin
                    unique case (fld)
                        CH_CTL: nxt_s.ctl[ch] = pwdata_in[CTL_W-1:0];
                        CH_SRC: nxt_s.src[ch] = pwdata_in;
                        CH_DST: nxt_s.dst[ch] = pwdata_in;
                        CH_CNT: nxt_s.cnt[ch] = pwdata_in[CNT_W-1:0];
                        default: nxt_s.cnt[ch] = s.cnt[ch];
                    endcase
                end else begin
                    unique case (paddr_in)
                        REG_STS: nxt_s.sts = s.sts & ~pwdata_in[NREQ-1:0];
                        REG_MASK: nxt_s.mask = pwdata_in[NREQ-1:0];
                        REG_CRC_CTL: nxt_s.crc_ctl = pwdata_in[CC_W-1:0];
                        REG_CRC_SEED: begin
                            nxt_s.crc_seed = pwdata_in;
                            nxt_s.seed_ld = 1'b1;
                        end
                        REG_CRC_WDATA: begin
                            // Ignored while DMA feeds the engine
                            if (!s.crc_ctl[CC_DMA]) begin
                                nxt_s.crc_go = 1'b1;
                                nxt_s.crc_data = pwdata_in;
                                nxt_s.crc_len = pdc_wid_bytes(s.crc_ctl[CC_PIO_WID +: 2]);
                            end
                        end
                        REG_CRC_SRC: nxt_s.crc_src = pwdata_in;
                        REG_CRC_CNT: nxt_s.crc_cnt = pwdata_in[CNT_W-1:0];
                        default: nxt_s.crc_src = s.crc_src;
                    endcase
                end
            end
        end

        // Data mover; its status sets come after the clears so they win
        unique case (s.state)
            ST_IDLE: begin
                if (gnt_vld) begin
                    nxt_s.cur = gnt;
                    nxt_s.m_req = 1'b1;
                    nxt_s.m_write = 1'b0;
                    if (gnt == 4'(CRC_CH)) begin
                        nxt_s.m_addr = s.crc_src;
                        nxt_s.m_size = WID_WORD;
                    end else begin
                        nxt_s.m_addr = s.src[gnt[3:0]];
                        nxt_s.m_size = s.ctl[gnt[3:0]][CTL_WID +: 2];
                    end
                    nxt_s.state = ST_READ;
                end
            end
            ST_READ: begin
                if (m_ready_in) begin
                    nxt_s.m_req = 1'b0;
                    nxt_s.hold = m_rdata_in;
                    nxt_s.state = ST_IDLE;
                    if (s.cur == 4'(CRC_CH)) begin
                        take = (s.crc_cnt > CNT_W'(4)) ? CNT_W'(4) : s.crc_cnt;
                        nxt_s.crc_go = 1'b1;
                        nxt_s.crc_data = m_rdata_in;
                        nxt_s.crc_len = take[2:0];
                        nxt_s.crc_src = s.crc_src + 32'h4;
                        nxt_s.crc_cnt = s.crc_cnt - take;
                        if (s.crc_cnt == take) begin
                            nxt_s.crc_ctl[CC_DMA_GO] = 1'b0;
                            nxt_s.sts[CRC_CH] = 1'b1;
                        end
                    end else if (s.ctl[s.cur][CTL_EN]) begin
                        nxt_s.m_req = 1'b1;
                        nxt_s.m_write = 1'b1;
                        nxt_s.m_addr = s.dst[s.cur];
                        nxt_s.m_wdata = m_rdata_in;
                        nxt_s.state = ST_WRITE;
                    end
                end
            end
            ST_WRITE: begin
                if (m_ready_in) begin
                    bytes = pdc_wid_bytes(s.ctl[s.cur][CTL_WID +: 2]);
                    nxt_s.m_req = 1'b0;
                    nxt_s.state = ST_IDLE;
                    nxt_s.ack[s.cur] = s.ctl[s.cur][CTL_DIR +: 2] != DIR_M2M;
                    if (s.ctl[s.cur][CTL_SRC_INC]) begin
                        nxt_s.src[s.cur] = s.src[s.cur] + {29'h0, bytes};
                    end
                    if (s.ctl[s.cur][CTL_DST_INC]) begin
                        nxt_s.dst[s.cur] = s.dst[s.cur] + {29'h0, bytes};
                    end
                    nxt_s.cnt[s.cur] = s.cnt[s.cur] - CNT_W'(1);
                    if (s.cnt[s.cur] == CNT_W'(1)) begin
                        nxt_s.ctl[s.cur][CTL_EN] = 1'b0;
                        nxt_s.sts[s.cur] = 1'b1;
                    end
                end
            end
            default: nxt_s.state = ST_IDLE;
        endcase
        nxt_s.irq = |(nxt_s.sts & nxt_s.mask);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s <= '0;
            s.crc_ctl <= CC_RST;
            s.crc_seed <= SEED_RST;
            s.state <= ST_IDLE;
        end else begin
            s <= nxt_s;
        end
    end

    assign prdata_out = s.prdata;
    assign pready_out = s.pready;
    assign pslverr_out = s.pslverr;
    assign m_req_out = s.m_req;
    assign m_write_out = s.m_write;
    assign m_addr_out = s.m_addr;
    assign m_size_out = s.m_size;
    assign m_wdata_out = s.m_wdata;
    assign per_ack_out = s.ack;
    assign irq_out = s.irq;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    logic beat_end;
    logic ctl_off;
    assign beat_end = s.state == ST_WRITE && m_ready_in;
    assign ctl_off = s.pready && acc && pwrite_in && hit[4] && fld == CH_CTL && !pwdata_in[CTL_EN];

    sequence bus_wait_s;
        s.m_req && !m_ready_in;
    endsequence
    sequence bus_held_s;
        s.m_req && $stable(s.m_addr) && $stable(s.m_write) && $stable(s.m_wdata);
    endsequence

    irq_level_a: assert property (irq_out == |(s.sts & s.mask)) else $error("irq differs from status");
    done_flag_a: assert property (beat_end && s.cnt[s.cur] == CNT_W'(1) |=> s.sts[$past(s.cur)])
        else $error("completion not flagged");
    ch_stop_a: assert property (ctl_off |=> !s.ctl[$past(ch)][CTL_EN]) else $error("channel still on");
    low_first_a: assert property (s.state == ST_IDLE && gnt_vld |=> ($past(req) & ((NREQ'(1) << s.cur) - NREQ'(1))) == '0)
        else $error("lower channel skipped");
    one_buffer_a: assert property (s.state == ST_WRITE |-> s.m_wdata == s.hold)
        else $error("write data not from buffer");
    bus_hold_a: assert property (bus_wait_s |=> bus_held_s) else $error("request dropped early");
    per_wait_a: assert property (s.state == ST_IDLE && gnt_vld && gnt < 4'(NCH) &&
        s.ctl[gnt[3:0]][CTL_DIR +: 2] != DIR_M2M |-> per_req_in[gnt[3:0]]) else $error("peripheral not requesting");
    src_step_a: assert property (beat_end && s.ctl[s.cur][CTL_SRC_INC] |=>
        s.src[$past(s.cur)] == $past(s.src[s.cur]) + {29'h0, $past(bytes)}) else $error("source not stepped");
    pio_block_a: assert property (s.pready && acc && pio_wr && s.crc_ctl[CC_DMA] |=> !s.crc_go)
        else $error("PIO fed in DMA mode");
endmodule

// ===== pdc_pkg.sv
package pdc_pkg;
    localparam int NCH = 9;
    localparam int NREQ = 10;
    localparam int CRC_CH = 9;

    // Per-channel block: base = channel * stride
    localparam logic [11:0] CH_STRIDE = 12'h010;
    localparam logic [11:0] CH_LIMIT = 12'h090;
    localparam logic [3:0] CH_CTL = 4'h0;
    localparam logic [3:0] CH_SRC = 4'h4;
    localparam logic [3:0] CH_DST = 4'h8;
    localparam logic [3:0] CH_CNT = 4'hC;
    localparam logic [11:0] REG_STS = 12'h100;
    localparam logic [11:0] REG_MASK = 12'h104;
    localparam logic [11:0] REG_CRC_CTL = 12'h108;
    localparam logic [11:0] REG_CRC_SEED = 12'h10C;
    localparam logic [11:0] REG_CRC_WDATA = 12'h110;
    localparam logic [11:0] REG_CRC_SUM = 12'h114;
    localparam logic [11:0] REG_CRC_SRC = 12'h118;
    localparam logic [11:0] REG_CRC_CNT = 12'h11C;

    // Channel control fields
    localparam int CTL_W = 7;
    localparam int CTL_EN = 0;
    localparam int CTL_DIR = 1;
    localparam int CTL_SRC_INC = 3;
    localparam int CTL_DST_INC = 4;
    localparam int CTL_WID = 5;
    localparam logic [CTL_W-1:0] CTL_RST = 7'h00;

    // CRC control fields
    localparam int CC_W = 10;
    localparam int CC_DMA = 0;
    localparam int CC_POLY = 1;
    localparam int CC_IN_REV = 3;
    localparam int CC_OUT_REV = 4;
    localparam int CC_IN_CPL = 5;
    localparam int CC_OUT_CPL = 6;
    localparam int CC_PIO_WID = 7;
    localparam int CC_DMA_GO = 9;
    localparam logic [CC_W-1:0] CC_RST = 10'h000;
    localparam logic [31:0] SEED_RST = 32'hFFFF_FFFF;

    typedef enum logic [1:0] {DIR_P2M = 2'h0, DIR_M2P = 2'h1, DIR_M2M = 2'h2} pdc_dir_t;
    typedef enum logic [1:0] {WID_WORD = 2'h0, WID_HALF = 2'h1, WID_BYTE = 2'h2} pdc_wid_t;
    typedef enum logic [1:0] {POLY_CCITT = 2'h0, POLY_8 = 2'h1, POLY_16 = 2'h2, POLY_32 = 2'h3} pdc_poly_t;

    localparam logic [31:0] POLY_CCITT_VAL = 32'h0000_1021;
    localparam logic [31:0] POLY_8_VAL = 32'h0000_0007;
    localparam logic [31:0] POLY_16_VAL = 32'h0000_8005;
    localparam logic [31:0] POLY_32_VAL = 32'h04C1_1DB7;

    function automatic logic [2:0] pdc_wid_bytes(input logic [1:0] wid);
        return (wid == WID_BYTE) ? 3'h1 : (wid == WID_HALF) ? 3'h2 : 3'h4;
    endfunction

    function automatic logic [31:0] pdc_poly_val(input logic [1:0] sel);
        return (sel == POLY_CCITT) ? POLY_CCITT_VAL : (sel == POLY_8) ? POLY_8_VAL :
               (sel == POLY_16) ? POLY_16_VAL : POLY_32_VAL;
    endfunction

    function automatic logic [31:0] pdc_poly_mask(input logic [1:0] sel);
        return (sel == POLY_8) ? 32'h0000_00FF : (sel == POLY_32) ? 32'hFFFF_FFFF : 32'h0000_FFFF;
    endfunction
endpackage

// ===== pdc_arb.sv
`timescale 1ns/100ps
module pdc_arb import pdc_pkg::*; #(
    parameter int N = NREQ
) (
    // Requests, bit 0 first
    input wire logic [N-1:0] req_in,
    // Winner
    output logic [3:0] gnt_out,
    output logic vld_out
);
    always_comb begin
        gnt_out = 4'h0;
        vld_out = 1'b0;
        // Walk downward so the lowest index wins
        for (int i = N - 1; i >= 0; i--) begin
            if (req_in[i]) begin
                gnt_out = 4'(i);
                vld_out = 1'b1;
            end
        end
    end
endmodule

// ===== pdc_crc.sv
`timescale 1ns/100ps
module pdc_crc import pdc_pkg::*; (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Setup
    input wire logic [1:0] poly_in,
    input wire logic in_rev_in,
    input wire logic in_cpl_in,
    input wire logic seed_ld_in,
    input wire logic [31:0] seed_in,
    // Data, low byte first
    input wire logic go_in,
    input wire logic [31:0] data_in,
    input wire logic [2:0] nbytes_in,
    // State
    output logic busy_out,
    output logic [31:0] crc_out
);
    typedef struct packed {
        logic [31:0] crc;
        logic [31:0] data;
        logic [2:0] left;
    } pdc_crc_st_t;

    pdc_crc_st_t s, nxt_s;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d, input logic [1:0] sel);
        logic [31:0] poly;
        logic [31:0] top;
        logic fb;
        poly = pdc_poly_val(sel);
        top = (pdc_poly_mask(sel) >> 1) + 32'h1;
        for (int i = 7; i >= 0; i--) begin
            fb = ((c & top) != 32'h0) ^ d[i];
            c = {c[30:0], 1'b0};
            if (fb) begin
                c = c ^ poly;
            end
        end
        return c & pdc_poly_mask(sel);
    endfunction

    logic [7:0] in_byte;

    always_comb begin
        nxt_s = s;
        in_byte = s.data[7:0];
        if (in_cpl_in) begin
            in_byte = ~in_byte;
        end
        if (in_rev_in) begin
            in_byte = {<<{in_byte}};
        end
        if (s.left != 3'h0) begin
            // One byte per clock
            nxt_s.crc = crc_byte(s.crc, in_byte, poly_in);
            nxt_s.data = {8'h00, s.data[31:8]};
            nxt_s.left = s.left - 3'h1;
        end else if (go_in) begin
            nxt_s.data = data_in;
            nxt_s.left = nbytes_in;
        end
        if (seed_ld_in) begin
            nxt_s.crc = seed_in & pdc_poly_mask(poly_in);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s <= '{crc: SEED_RST, data: 32'h0, left: 3'h0};
        end else begin
            s <= nxt_s;
        end
    end

    assign busy_out = (s.left != 3'h0);
    assign crc_out = s.crc;

    sequence word_start_s;
        go_in && !busy_out && nbytes_in == 3'h4;
    endsequence
    sequence four_busy_s;
        busy_out [*4] ##1 !busy_out;
    endsequence
    property word_time_p;
        @(posedge clk_in) disable iff (rst_in) word_start_s |=> four_busy_s;
    endproperty
    crc_word_time_a: assert property (word_time_p) else $error("word not done in four cycles");
endmodule

// ===== pdc_mem.sv
`timescale 1ns/100ps
module pdc_mem (
    // Clock and pacing
    input wire logic clk_in,
    input wire logic slow_in,
    // Master bus
    input wire logic req_in,
    input wire logic write_in,
    input wire logic [31:0] addr_in,
    input wire logic [1:0] size_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out,
    output logic ready_out
);
    logic [31:0] mem [256];
    logic [31:0] word;
    logic [4:0] sh;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 32'h5A00_0000 | i;
        end
        ready_out = 1'b0;
    end
    assign word = mem[addr_in[9:2]];
    assign sh = {addr_in[1:0], 3'h0};
    // Slow mode answers every other cycle, like a busy slave
    always @(posedge clk_in) begin
        ready_out <= req_in & (~slow_in | ~ready_out);
        if (req_in & ready_out & write_in) begin
            case (size_in)
                2'h2: mem[addr_in[9:2]][sh +: 8] <= wdata_in[7:0];
                2'h1: mem[addr_in[9:2]][sh +: 16] <= wdata_in[15:0];
                default: mem[addr_in[9:2]] <= wdata_in;
            endcase
        end
    end
    // Inverted data while not answering, so a stale read never matches
    assign rdata_out = ready_out ? word >> sh : ~word;
endmodule

// ===== pdc_top_tb.sv
`timescale 1ns/100ps
module pdc_top_tb import pdc_pkg::*;;
    logic clk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, m_addr, m_wdata, m_rdata, rd, part;
    logic pready, pslverr, m_req, m_write, m_ready, irq, err;
    logic [1:0] m_size;
    logic [NCH-1:0] per_req = 9'h000, per_ack, acks = 9'h000;
    int n_errors = 0, compares = 0, cyc = 0;
    pdc_top pdc_top_i (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .m_req_out(m_req), .m_write_out(m_write),
        .m_addr_out(m_addr), .m_size_out(m_size), .m_wdata_out(m_wdata), .m_rdata_in(m_rdata),
        .m_ready_in(m_ready), .per_req_in(per_req), .per_ack_out(per_ack), .irq_out(irq));
    pdc_mem pdc_mem_i (.clk_in(clk_in), .slow_in(slow), .req_in(m_req), .write_in(m_write),
        .addr_in(m_addr), .size_in(m_size), .wdata_in(m_wdata), .rdata_out(m_rdata), .ready_out(m_ready));
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    // Whole run needs a few hundred cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        // Collect peripheral acknowledge pulses
        if (!rst_in) acks <= acks | per_ack;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chan(input int n, input logic [31:0] s, input logic [31:0] d, input logic [31:0] c,
                        input logic [31:0] ctl);
        apb(1'b1, 12'(n * 16) + 12'h4, s);
        apb(1'b1, 12'(n * 16) + 12'h8, d);
        apb(1'b1, 12'(n * 16) + 12'hC, c);
        apb(1'b1, 12'(n * 16), ctl);
    endtask
    task automatic wait_sts(input logic [31:0] bit_m);
        for (int i = 0; i < 60; i++) begin
            apb(1'b0, REG_STS, 32'h0);
            if ((rd & bit_m) != 0) break;
        end
    endtask
    function automatic logic [31:0] crc_exp(int p, logic [31:0] d, int nb, logic rv, logic oc, logic [31:0] sd);
        logic [31:0] pv, mk, s, r;
        logic [7:0] b;
        int w;
        pv = p == 0 ? 32'h1021 : p == 1 ? 32'h07 : p == 2 ? 32'h8005 : 32'h04C1_1DB7;
        w = p == 1 ? 8 : p == 3 ? 32 : 16;
        mk = w == 32 ? 32'hFFFF_FFFF : (32'h1 << w) - 1;
        s = sd & mk;
        for (int k = 0; k < nb; k++) begin
            b = d[8 * k +: 8];
            if (rv) b = {<<{b}};
            for (int j = 7; j >= 0; j--) begin
                s = ((s << 1) & mk) ^ ((s[w - 1] ^ b[j]) ? pv : 32'h0);
            end
        end
        // Reverse flag covers input bytes and the checksum together
        r = {<<{s}};
        if (rv) s = r >> (32 - w);
        return oc ? ~s & mk : s;
    endfunction
    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        apb(1'b0, REG_CRC_SEED, 32'h0);
        chk("seed reset", SEED_RST, rd);
        apb(1'b0, 12'h200, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b1, REG_MASK, 32'h3FF);
        slow <= 1'b1;
        chan(1, 32'h010, 32'h200, 32'h2, 32'h1D);
        wait_sts(32'h2);
        chk("irq set", 32'h1, {31'h0, irq});
        chk("m2m word0", 32'h5A00_0004, pdc_mem_i.mem[8'h80]);
        chk("m2m word1", 32'h5A00_0005, pdc_mem_i.mem[8'h81]);
        apb(1'b1, REG_STS, 32'h2);
        apb(1'b0, REG_STS, 32'h0);
        chk("status clear", 32'h0, rd);
        chk("irq clear", 32'h0, {31'h0, irq});
        chk("m2m no ack", 32'h0, {23'h0, acks});
        $display("test m2m done");
        chan(0, 32'h020, 32'h300, 32'h1, 32'h51);
        chan(3, 32'h030, 32'h310, 32'h1, 32'h33);
        repeat (10) @(posedge clk_in);
        chk("no req no move", 32'h0, {31'h0, m_req});
        per_req <= 9'h009;
        for (int i = 0; i < 20 && m_req !== 1'b1; i++) @(posedge clk_in);
        chk("priority", 32'h020, m_addr);
        wait_sts(32'h9);
        wait_sts(32'h8);
        per_req <= 9'h000;
        chk("byte p2m", 32'h5A00_0008, pdc_mem_i.mem[8'hC0]);
        chk("half m2p ch3", 32'h5A00_000C, pdc_mem_i.mem[8'hC4]);
        chk("per ack", 32'h9, {23'h0, acks});
        apb(1'b1, REG_STS, 32'h9);
        $display("test priority done");
        chan(5, 32'h040, 32'h320, 32'h1, 32'h51);
        apb(1'b1, 12'h050, 32'h0);
        per_req <= 9'h020;
        repeat (20) @(posedge clk_in);
        apb(1'b0, REG_STS, 32'h0);
        chk("stopped status", 32'h0, rd);
        chk("stopped mem", 32'h5A00_00C8, pdc_mem_i.mem[8'hC8]);
        per_req <= 9'h000;
        $display("test stop done");
        for (int i = 0; i < 6; i++) begin
            logic [31:0] ctl;
            logic [31:0] dat;
            int p;
            p = i == 4 ? 3 : i == 5 ? 1 : i;
            dat = i == 5 ? 32'h1234_5678 : 32'h5A;
            ctl = (p << 1) | (i == 4 ? 32'h58 : 32'h0) | (i == 5 ? 32'h20 : 32'h100);
            apb(1'b1, REG_CRC_CTL, ctl);
            apb(1'b1, REG_CRC_SEED, 32'hC3A5_0F1E);
            apb(1'b1, REG_CRC_WDATA, dat);
            // Engine may still be shifting a word in
            repeat (4) @(posedge clk_in);
            apb(1'b0, REG_CRC_SUM, 32'h0);
            // Input complement equals feeding the inverted word
            part = i == 5 ? ~dat : dat;
            chk("crc sum", crc_exp(p, part, i == 5 ? 4 : 1, i == 4, i == 4, 32'hC3A5_0F1E), rd);
        end
        $display("test crc done");
        apb(1'b1, REG_CRC_CTL, 32'h7);
        apb(1'b1, REG_CRC_SEED, 32'h0F0F_0F0F);
        apb(1'b1, REG_CRC_SRC, 32'h040);
        apb(1'b1, REG_CRC_CNT, 32'h6);
        apb(1'b1, REG_CRC_WDATA, 32'hDEAD_BEEF);
        apb(1'b1, REG_CRC_CTL, 32'h207);
        wait_sts(32'h200);
        chk("crc dma done", 32'h200, rd & 32'h200);
        repeat (4) @(posedge clk_in);
        apb(1'b0, REG_CRC_SUM, 32'h0);
        part = crc_exp(3, 32'h5A00_0010, 4, 1'b0, 1'b0, 32'h0F0F_0F0F);
        chk("crc dma sum", crc_exp(3, 32'h5A00_0011, 2, 1'b0, 1'b0, part), rd);
        apb(1'b0, REG_CRC_CTL, 32'h0);
        chk("crc go clear", 32'h7, rd);
        $display("test crc dma done");
        give_verdict();
    end
endmodule
